/* verilog/rtzs_ctl.sv */
/*
 per-timeslot receive control: timeslot control registers over axi4-lite,
 link controller routing, zero-suppression handling, backplane fifo.
 assumes framer octets arrive on aclk with slot number and frame flags.
*/
// Chosen here: the address map and the AXI4-Lite register port.
`timescale 1ns/1ns
module rtzs_ctl (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write
    input wire logic [rtzs_pkg::ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [rtzs_pkg::DATA_W-1:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // axi4-lite read
    input wire logic [rtzs_pkg::ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [rtzs_pkg::DATA_W-1:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // received octets from the framer
    input wire logic line_valid,
    output logic line_ready,
    input wire logic [7:0] line_octet,
    input wire logic [rtzs_pkg::SLOT_W-1:0] line_slot,
    input wire logic line_sig_frame,
    input wire logic line_de,
    // backplane side
    output logic bp_valid,
    input wire logic bp_ready,
    output logic [7:0] bp_octet,
    output logic [rtzs_pkg::SLOT_W-1:0] bp_slot,
    // link controllers
    output logic [2:0] dl_valid,
    output logic [7:0] dl_octet,
    output logic [7:0] dl_mask
);
    import rtzs_pkg::*;

    function automatic logic is_ts(input logic [IDX_W-1:0] idx);
        return (idx >= IDX_TS_FIRST) && (idx <= IDX_TS_LAST);
    endfunction : is_ts

    function automatic logic [SLOT_W-1:0] ts_of(input logic [IDX_W-1:0] idx);
        logic [IDX_W-1:0] d;
        d = idx - IDX_TS_FIRST;
        return d[SLOT_W-1:0];
    endfunction : ts_of

    logic [7:0] ts_ctrl [TS_COUNT];
    logic [7:0] next_ts_ctrl [TS_COUNT];
    logic [1:0] link_src, next_link_src;
    rtzs_wr_t wr_state, next_wr_state;
    logic [IDX_W-1:0] wr_idx, next_wr_idx, eff_idx;
    logic [7:0] wr_byte, next_wr_byte, eff_byte;
    logic wr_lane, next_wr_lane, eff_lane, do_write;
    logic next_awready, next_wready, next_bvalid;
    logic [1:0] next_bresp;
    logic aw_hs, w_hs, ar_hs;
    rtzs_rd_t rd_state, next_rd_state;
    logic [IDX_W-1:0] rd_idx;
    logic next_arready, next_rvalid;
    logic [DATA_W-1:0] next_rdata;
    logic [1:0] next_rresp;
    logic [SLOT_W-1:0] last_slot, next_last_slot;
    logic [LEVEL_W-1:0] fifo_level;
    logic [FIFO_W-1:0] fifo_out;
    logic [7:0] cur_ctrl, proc_octet, proc_mask, next_dl_octet, next_dl_mask;
    rtzs_lc_t cur_sel;
    rtzs_zs_t cur_zs;
    logic [2:0] route, next_dl_valid;
    logic push;

    assign aw_hs = awvalid && awready;
    assign w_hs = wvalid && wready;
    assign ar_hs = arvalid && arready;

    // ---------------------------------------------------------------
    // register writes
    // ---------------------------------------------------------------
    always_comb
    begin
        next_wr_state = wr_state;
        next_wr_idx = wr_idx;
        next_wr_byte = wr_byte;
        next_wr_lane = wr_lane;
        next_awready = awready;
        next_wready = wready;
        next_bvalid = bvalid;
        next_bresp = bresp;
        next_ts_ctrl = ts_ctrl;
        next_link_src = link_src;
        do_write = 1'b0;
        eff_idx = aw_hs ? awaddr[IDX_LSB +: IDX_W] : wr_idx;
        eff_byte = w_hs ? wdata[7:0] : wr_byte;
        eff_lane = w_hs ? wstrb[0] : wr_lane;
        unique case (wr_state)
            WR_IDLE:
            begin
                if (aw_hs && w_hs)
                    do_write = 1'b1;
                else if (aw_hs)
                begin
                    next_wr_state = WR_ADDR;
                    next_awready = 1'b0;
                end
                else if (w_hs)
                begin
                    next_wr_state = WR_DATA;
                    next_wready = 1'b0;
                end
            end
            WR_ADDR: do_write = w_hs;
            WR_DATA: do_write = aw_hs;
            WR_RESP:
            begin
                if (bready)
                begin
                    next_wr_state = WR_IDLE;
                    next_bvalid = 1'b0;
                    next_awready = 1'b1;
                    next_wready = 1'b1;
                end
            end
        endcase
        next_wr_idx = eff_idx;
        next_wr_byte = eff_byte;
        next_wr_lane = eff_lane;
        if (do_write)
        begin
            next_wr_state = WR_RESP;
            next_awready = 1'b0;
            next_wready = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = RESP_OKAY;
            if (is_ts(eff_idx))
            begin
                if (eff_lane)
                    next_ts_ctrl[ts_of(eff_idx)] = eff_byte;
            end
            else if (eff_idx == IDX_LINK_SEL)
            begin
                if (eff_lane)
                    next_link_src = eff_byte[LINK_SRC_LSB +: FIELD_W];
            end
            else if (eff_idx != IDX_STATUS)
                next_bresp = RESP_SLVERR;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            wr_state <= WR_IDLE;
            wr_idx <= '0;
            wr_byte <= '0;
            wr_lane <= 1'b0;
            awready <= 1'b1;
            wready <= 1'b1;
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
            link_src <= LINK_SRC_RST;
            for (int i = 0; i < TS_COUNT; i++)
                ts_ctrl[i] <= TS_CTRL_RST;
        end
        else
        begin
            wr_state <= next_wr_state;
            wr_idx <= next_wr_idx;
            wr_byte <= next_wr_byte;
            wr_lane <= next_wr_lane;
            awready <= next_awready;
            wready <= next_wready;
            bvalid <= next_bvalid;
            bresp <= next_bresp;
            link_src <= next_link_src;
            ts_ctrl <= next_ts_ctrl;
        end
    end

    // ---------------------------------------------------------------
    // register reads
    // ---------------------------------------------------------------
    assign rd_idx = araddr[IDX_LSB +: IDX_W];

    always_comb
    begin
        next_rd_state = rd_state;
        next_arready = arready;
        next_rvalid = rvalid;
        next_rdata = rdata;
        next_rresp = rresp;
        unique case (rd_state)
            RD_IDLE:
            begin
                if (ar_hs)
                begin
                    next_rd_state = RD_DATA;
                    next_arready = 1'b0;
                    next_rvalid = 1'b1;
                    next_rresp = RESP_OKAY;
                    next_rdata = '0;
                    if (is_ts(rd_idx))
                        next_rdata[7:0] = ts_ctrl[ts_of(rd_idx)];
                    else if (rd_idx == IDX_LINK_SEL)
                        next_rdata[LINK_SRC_LSB +: FIELD_W] = link_src;
                    else if (rd_idx == IDX_STATUS)
                    begin
                        next_rdata[STAT_LEVEL_LSB +: LEVEL_W] = fifo_level;
                        next_rdata[STAT_SLOT_LSB +: SLOT_W] = last_slot;
                    end
                    else
                        next_rresp = RESP_SLVERR;
                end
            end
            RD_DATA:
            begin
                if (rready)
                begin
                    next_rd_state = RD_IDLE;
                    next_arready = 1'b1;
                    next_rvalid = 1'b0;
                end
            end
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rd_state <= RD_IDLE;
            arready <= 1'b1;
            rvalid <= 1'b0;
            rdata <= '0;
            rresp <= RESP_OKAY;
        end
        else
        begin
            rd_state <= next_rd_state;
            arready <= next_arready;
            rvalid <= next_rvalid;
            rdata <= next_rdata;
            rresp <= next_rresp;
        end
    end

    // ---------------------------------------------------------------
    // timeslot datapath
    // ---------------------------------------------------------------
    always_comb
    begin
        push = line_valid && line_ready;
        cur_ctrl = (line_slot < TS_COUNT) ? ts_ctrl[line_slot] : TS_CTRL_RST;
        cur_sel = rtzs_lc_t'(cur_ctrl[SEL_LSB +: FIELD_W]);
        cur_zs = rtzs_zs_t'(cur_ctrl[ZS_LSB +: FIELD_W]);
        proc_octet = line_octet;
        proc_mask = MASK_ALL;
        unique case (cur_zs)
            ZS_NONE: proc_mask = MASK_ALL;
            ZS_BIT7: proc_mask = MASK_BIT7;
            ZS_ALT:
            begin
                if (!line_sig_frame)
                    proc_mask = MASK_BIT8;
                else if (!line_octet[SIG_BIT])
                    proc_mask = MASK_BIT7;
            end
            ZS_DDS: proc_octet = DDS_OCTET;
        endcase
        route = DL_NONE;
        unique case (cur_sel)
            LC_FIRST: route = DL_FIRST;
            LC_SECOND: route = DL_SECOND;
            LC_THIRD: route = DL_THIRD;
            LC_DEFER:
            begin
                unique case (rtzs_lc_t'(link_src))
                    LC_FIRST: route = DL_FIRST;
                    LC_SECOND: route = DL_SECOND;
                    LC_THIRD: route = DL_THIRD;
                    LC_DEFER: route = DL_NONE;
                endcase
            end
        endcase
        next_dl_valid = (push && line_de) ? route : DL_NONE;
        next_dl_octet = push ? proc_octet : dl_octet;
        next_dl_mask = push ? proc_mask : dl_mask;
        next_last_slot = push ? line_slot : last_slot;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            dl_valid <= DL_NONE;
            dl_octet <= '0;
            dl_mask <= MASK_ALL;
            last_slot <= '0;
        end
        else
        begin
            dl_valid <= next_dl_valid;
            dl_octet <= next_dl_octet;
            dl_mask <= next_dl_mask;
            last_slot <= next_last_slot;
        end
    end

    rtzs_fifo #(
        .WIDTH(FIFO_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .aclk(aclk),
        .aresetn(aresetn),
        .in_valid(line_valid),
        .in_ready(line_ready),
        .in_data({line_slot, proc_octet}),
        .out_valid(bp_valid),
        .out_ready(bp_ready),
        .out_data(fifo_out),
        .level(fifo_level)
    );

    assign bp_octet = fifo_out[7:0];
    assign bp_slot = fifo_out[FIFO_W-1:8];

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    logic ar_ts;
    logic [7:0] ar_ts_val;
    assign ar_ts = is_ts(rd_idx);
    assign ar_ts_val = ar_ts ? ts_ctrl[ts_of(rd_idx)] : TS_CTRL_RST;

    property p_ts_read;
        ar_hs && ar_ts |=> rvalid && rresp == RESP_OKAY && rdata[7:0] == $past(ar_ts_val);
    endproperty
    a_ts_read: assert property (p_ts_read) else $error("timeslot read mismatch");
    property p_route_first;
        push && line_de && cur_sel == LC_FIRST |=> dl_valid == DL_FIRST;
    endproperty
    a_route_first: assert property (p_route_first) else $error("first controller not hit");
    property p_route_second;
        push && line_de && cur_sel == LC_SECOND |=> dl_valid == DL_SECOND;
    endproperty
    a_route_second: assert property (p_route_second) else $error("second controller not hit");
    property p_route_third;
        push && line_de && cur_sel == LC_THIRD |=> dl_valid == DL_THIRD;
    endproperty
    a_route_third: assert property (p_route_third) else $error("third controller not hit");
    property p_route_defer;
        push && line_de && cur_sel == LC_DEFER |=> dl_valid == ($past(link_src) == LC_FIRST ? DL_FIRST :
            $past(link_src) == LC_SECOND ? DL_SECOND : $past(link_src) == LC_THIRD ? DL_THIRD : DL_NONE);
    endproperty
    a_route_defer: assert property (p_route_defer) else $error("deferred routing wrong");
    property p_zs_none;
        push && cur_zs == ZS_NONE |=> dl_mask == MASK_ALL && dl_octet == $past(line_octet);
    endproperty
    a_zs_none: assert property (p_zs_none) else $error("octet altered without suppression");
    property p_zs_bit7;
        push && cur_zs == ZS_BIT7 |=> dl_mask == MASK_BIT7;
    endproperty
    a_zs_bit7: assert property (p_zs_bit7) else $error("bit 7 not marked stuffed");
    property p_zs_alt;
        push && cur_zs == ZS_ALT && !line_sig_frame |=> dl_mask == MASK_BIT8;
    endproperty
    a_zs_alt: assert property (p_zs_alt) else $error("bit 8 not marked stuffed");
    property p_zs_dds;
        push && cur_zs == ZS_DDS |=> dl_octet == DDS_OCTET ##[0:40] (bp_valid && bp_octet == DDS_OCTET);
    endproperty
    a_zs_dds: assert property (p_zs_dds) else $error("dds code not substituted");
    property p_bvalid_hold;
        bvalid && !bready |=> bvalid;
    endproperty
    a_bvalid_hold: assert property (p_bvalid_hold) else $error("bvalid dropped early");

    c_defer: cover property (push && line_de && cur_sel == LC_DEFER);
    c_fifo_full: cover property (!line_ready);
    c_write_ts: cover property (do_write && is_ts(eff_idx));
    c_dds: cover property (push && cur_zs == ZS_DDS);
endmodule : rtzs_ctl

/* verilog/rtzs_pkg.sv */
/*
 constants, field layouts and state encodings for the receive timeslot
 link and zero-suppression control block.
 assumes a 50 MHz aclk and AXI4-Lite with 32-bit data.
*/
package rtzs_pkg;
    // ---------------------------------------------------------------
    // bus and register map
    // ---------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int IDX_W = 10;
    localparam int IDX_LSB = 2;
    localparam int TS_COUNT = 24;
    localparam int SLOT_W = 5;
    localparam logic [IDX_W-1:0] IDX_TS_FIRST = 10'h360;
    localparam logic [IDX_W-1:0] IDX_TS_LAST = 10'h377;
    localparam logic [IDX_W-1:0] IDX_LINK_SEL = 10'h10C;
    localparam logic [IDX_W-1:0] IDX_STATUS = 10'h3F0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // ---------------------------------------------------------------
    // field layout and reset values
    // ---------------------------------------------------------------
    localparam int FIELD_W = 2;
    localparam int SEL_LSB = 6;
    localparam int ZS_LSB = 4;
    localparam int LINK_SRC_LSB = 0;
    localparam int LEVEL_W = 4;
    localparam int STAT_LEVEL_LSB = 0;
    localparam int STAT_SLOT_LSB = 8;
    localparam int SIG_BIT = 0;
    localparam logic [7:0] TS_CTRL_RST = 8'h00;
    localparam logic [1:0] LINK_SRC_RST = 2'h0;
    // ---------------------------------------------------------------
    // codes
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {
        LC_FIRST = 2'b00,
        LC_SECOND = 2'b01,
        LC_DEFER = 2'b10,
        LC_THIRD = 2'b11
    } rtzs_lc_t;
    typedef enum logic [1:0] {
        ZS_NONE = 2'b00,
        ZS_BIT7 = 2'b01,
        ZS_ALT = 2'b10,
        ZS_DDS = 2'b11
    } rtzs_zs_t;
    localparam logic [2:0] DL_NONE = 3'h0;
    localparam logic [2:0] DL_FIRST = 3'h1;
    localparam logic [2:0] DL_SECOND = 3'h2;
    localparam logic [2:0] DL_THIRD = 3'h4;
    localparam logic [7:0] DDS_OCTET = 8'h98;
    localparam logic [7:0] MASK_ALL = 8'hFF;
    localparam logic [7:0] MASK_BIT7 = 8'hFD;
    localparam logic [7:0] MASK_BIT8 = 8'hFE;
    // ---------------------------------------------------------------
    // buffering and bus state machines
    // ---------------------------------------------------------------
    localparam int FIFO_DEPTH = 8;
    localparam int FIFO_W = 13;
    typedef enum logic [1:0] {
        WR_IDLE = 2'b00,
        WR_ADDR = 2'b01,
        WR_RESP = 2'b11,
        WR_DATA = 2'b10
    } rtzs_wr_t;
    typedef enum logic {
        RD_IDLE = 1'b0,
        RD_DATA = 1'b1
    } rtzs_rd_t;
endpackage : rtzs_pkg

/* verilog/rtzs_fifo.sv */
/*
 synchronous valid/ready fifo with registered flags and fill level.
 assumes a power-of-two depth and a single clock.
*/
`timescale 1ns/1ns
module rtzs_fifo #(
    parameter int WIDTH = rtzs_pkg::FIFO_W,
    parameter int DEPTH = rtzs_pkg::FIFO_DEPTH
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // filling side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // draining side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    // fill level
    output logic [$clog2(DEPTH+1)-1:0] level
);
    import rtzs_pkg::*;
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH+1);
    localparam logic [CW-1:0] FULL_C = CW'(DEPTH);
    localparam logic [CW-1:0] ONE_C = CW'(1);
    localparam logic [CW-1:0] EMPTY_C = CW'(0);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [PW-1:0] next_wr_ptr;
    logic [PW-1:0] next_rd_ptr;
    logic [CW-1:0] next_level;
    logic next_in_ready;
    logic next_out_valid;
    logic push;
    logic pop;

    // ---------------------------------------------------------------
    // pointers and flags
    // ---------------------------------------------------------------
    always_comb
    begin
        push = in_valid && in_ready;
        pop = out_valid && out_ready;
        next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
        next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
        next_level = level;
        if (push && !pop)
            next_level = level + ONE_C;
        else if (pop && !push)
            next_level = level - ONE_C;
        next_in_ready = next_level != FULL_C;
        next_out_valid = next_level != EMPTY_C;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            level <= EMPTY_C;
            in_ready <= 1'b1;
            out_valid <= 1'b0;
        end
        else
        begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            level <= next_level;
            in_ready <= next_in_ready;
            out_valid <= next_out_valid;
        end
    end

    // ---------------------------------------------------------------
    // storage
    // ---------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (push)
            mem[wr_ptr] <= in_data;
    end

    assign out_data = mem[rd_ptr];
endmodule : rtzs_fifo

/* dv/rtzs_framer_model.sv */
/*
 line framer and backplane stand-in: sends octets, drains the backplane.
 assumes its tasks are called right after a rising edge of aclk.
*/
`timescale 1ns/1ns
module rtzs_framer_model (
    // clock
    input wire logic aclk,
    // line side
    input wire logic line_ready,
    output logic line_valid,
    output logic [7:0] line_octet,
    output logic [rtzs_pkg::SLOT_W-1:0] line_slot,
    output logic line_sig_frame,
    output logic line_de,
    // backplane side
    input wire logic bp_hold,
    output logic bp_ready
);
    import rtzs_pkg::*;
    initial
    begin
        line_valid = 1'b0;
        line_octet = 8'h00;
        line_slot = 5'h00;
        line_sig_frame = 1'b0;
        line_de = 1'b0;
        bp_ready = 1'b0;
    end
    // slow sink: random gaps, full stop while held
    always @(posedge aclk)
        bp_ready <= !bp_hold && ($urandom_range(3) != 0);
    // holds the octet until the edge that takes it
    task send(input logic [7:0] o, input logic [4:0] s, input logic sg, input logic de);
        line_octet <= o;
        line_slot <= s;
        line_sig_frame <= sg;
        line_de <= de;
        line_valid <= 1'b1;
        do
            @(posedge aclk);
        while (line_ready !== 1'b1);
    endtask : send
    // released octet and slot lines show the inverse of the last value
    task idle;
        line_valid <= 1'b0;
        line_octet <= ~line_octet;
        line_slot <= ~line_slot;
    endtask : idle
endmodule : rtzs_framer_model

/* dv/testbench.sv */
/*
 self-checking bench for the receive timeslot control block.
 assumes the framer model above and a 50 MHz aclk.
*/
`timescale 1ns/1ns
module testbench;
    import rtzs_pkg::*;
    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, line_valid, line_ready, line_sig_frame, line_de;
    logic bp_valid, bp_ready, bp_hold;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata, d;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, src;
    logic [7:0] line_octet, bp_octet, dl_octet, dl_mask;
    logic [4:0] line_slot, bp_slot, s;
    logic [2:0] dl_valid;
    logic [39:0] r_q[$], b_q[$], bp_q[$], dl_q[$];
    logic [7:0] ctl[32];
    int num_errors, comparisons;
    rtzs_ctl uut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp,
        .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .line_valid,
        .line_ready, .line_octet, .line_slot, .line_sig_frame, .line_de, .bp_valid, .bp_ready, .bp_octet,
        .bp_slot, .dl_valid, .dl_octet, .dl_mask);
    rtzs_framer_model fm (.aclk, .line_ready, .line_valid, .line_octet, .line_slot, .line_sig_frame,
        .line_de, .bp_hold, .bp_ready);
    initial
    begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end
    task chk(input string n, input logic [39:0] e, input logic [39:0] g);
        comparisons++;
        if (g !== e)
        begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    // ---------------------------------------------------------------
    // output watcher
    // ---------------------------------------------------------------
    always @(posedge aclk)
        if (aresetn === 1'b1)
        begin
            if ((bvalid & bready) === 1'b1)
                chk("bresp", b_q.pop_front(), 40'(bresp));
            if ((rvalid & rready) === 1'b1)
                chk("rdata", r_q.pop_front(), 40'({rresp, rdata}));
            if ((bp_valid & bp_ready) === 1'b1)
                chk("backplane", bp_q.pop_front(), 40'({bp_slot, bp_octet}));
            if (dl_valid !== 3'h0)
                chk("link", dl_q.pop_front(), 40'({dl_valid, dl_octet, dl_mask}));
        end
    task wr(input logic [11:0] a, input logic [31:0] v, input logic [1:0] e);
        b_q.push_back(40'(e));
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        forever
        begin
            @(posedge aclk);
            if (awready)
                awvalid <= 1'b0;
            if (wready)
                wvalid <= 1'b0;
            if (bvalid)
                break;
        end
    endtask : wr
    task rd(input logic [11:0] a, input logic [33:0] e);
        r_q.push_back(40'(e));
        araddr <= a;
        arvalid <= 1'b1;
        forever
        begin
            @(posedge aclk);
            if (arready)
                arvalid <= 1'b0;
            if (rvalid)
                break;
        end
    endtask : rd
    task tx(input logic [4:0] t, input logic [7:0] o, input logic sg, input logic de);
        logic [7:0] c, m, q;
        logic [1:0] r;
        c = ctl[t];
        q = (c[5:4] == 2'h3) ? 8'h98 : o;
        m = (c[5:4] == 2'h1) ? 8'hFD : (c[5:4] != 2'h2) ? 8'hFF : !sg ? 8'hFE : o[0] ? 8'hFF : 8'hFD;
        r = (c[7:6] == 2'h2) ? src : c[7:6];
        bp_q.push_back(40'({t, q}));
        if (de && r != 2'h2)
            dl_q.push_back(40'({r == 2'h3, r == 2'h1, r == 2'h0, q, m}));
        fm.send(o, t, sg, de);
    endtask : tx
    task end_of_test;
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : end_of_test
    initial
    begin
        #200000;
        num_errors++;
        end_of_test();
    end
    // ---------------------------------------------------------------
    // tests
    // ---------------------------------------------------------------
    initial
    begin
        {aresetn, awvalid, wvalid, arvalid, bp_hold, awaddr, araddr, wdata, src} = '0;
        // response readies stay high so back-to-back calls never reassign them
        {bready, rready} = 2'h3;
        wstrb = 4'hF;
        foreach (ctl[i])
            ctl[i] = 8'h00;
        void'($urandom(66));
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        for (int i = 0; i < 24; i++)
            rd(12'hD80 + 12'(4 * i), 34'h0);
        rd(12'h430, 34'h0);
        rd(12'h004, {2'h2, 32'h0});
        wr(12'h004, 32'hFFFFFFFF, 2'h2);
        for (int i = 0; i < 24; i += 23)
        begin
            d = $urandom;
            ctl[i] = d[7:0];
            wr(12'hD80 + 12'(4 * i), d, 2'h0);
            rd(12'hD80 + 12'(4 * i), 34'(d[7:0]));
        end
        rd(12'hD84, 34'h0);
        wstrb <= 4'hE;
        wr(12'hD84, 32'h000000FF, 2'h0);
        wstrb <= 4'hF;
        rd(12'hD84, 34'h0);
        wr(12'hFC0, 32'h0000FFFF, 2'h0);
        rd(12'hFC0, 34'h0);
        $display("test 1 done");
        for (int k = 0; k < 4; k++)
        begin
            src = 2'(k);
            wr(12'h430, 32'(k), 2'h0);
            for (int c = 0; c < 16; c++)
            begin
                s = 5'($urandom_range(23));
                d = $urandom;
                ctl[s] = {4'(c), d[3:0]};
                wr(12'hD80 + {5'h0, s, 2'h0}, {d[31:8], ctl[s]}, 2'h0);
                for (int j = 0; j < 4; j++)
                    tx(s, {d[15:9], j[1]}, j[0], 1'b1);
                fm.idle();
            end
        end
        $display("test 2 done");
        repeat (30) @(posedge aclk);
        bp_hold <= 1'b1;
        repeat (3) @(posedge aclk);
        for (int k = 0; k < 8; k++)
        begin
            d = $urandom;
            tx(d[4:0], d[15:8], d[16], d[17]);
        end
        fm.idle();
        repeat (3) @(posedge aclk);
        chk("line_ready", 40'h0, 40'(line_ready));
        rd(12'hFC0, {21'h0, d[4:0], 8'h08});
        bp_hold <= 1'b0;
        tx(5'd3, 8'h00, 1'b0, 1'b1);
        fm.idle();
        repeat (40) @(posedge aclk);
        chk("pending", 40'h0, 40'(bp_q.size() + dl_q.size() + r_q.size() + b_q.size()));
        $display("test 3 done");
        end_of_test();
    end
endmodule : testbench
